// file: common/tas_defs.vh
// shared constants of the thermal alert target
`ifndef TAS_DEFS_VH
`define TAS_DEFS_VH

// register pointer values
`define TAS_PTR_TEMP 2'h0
`define TAS_PTR_CONF 2'h1
`define TAS_PTR_CLR 2'h2
`define TAS_PTR_TRIP 2'h3

// settings register fields
`define TAS_SD_BIT 0
`define TAS_MODE_BIT 1
`define TAS_POL_BIT 2
`define TAS_FQ_HI 4
`define TAS_FQ_LO 3

// power-up values
`define TAS_CONF_RST 8'h00
`define TAS_TRIP_RST 9'h0a0
`define TAS_CLR_RST 9'h096
`define TAS_PTR_RST 2'h0

// consecutive faults needed per fault-count code
`define TAS_FQ_N0 3'h1
`define TAS_FQ_N1 3'h2
`define TAS_FQ_N2 3'h4
`define TAS_FQ_N3 3'h6

// serial byte framing
`define TAS_BITS_DONE 4'h8
`define TAS_CNT_ZERO 4'h0
`define TAS_CNT_ONE 4'h1

`endif

// file: hdl/tas_pin_sync.v
// pin synchroniser and start/stop/edge detection of the serial link
`timescale 1ns/1ps

module tas_pin_sync (
    input wire sys_clk,
    input wire srst,
    input wire scl,
    input wire sda,
    output wire sda_s,
    output wire scl_rise,
    output wire scl_fall,
    output wire start_det,
    output wire stop_det
);

reg scl_m_reg;
reg sda_m_reg;
reg scl_s_reg;
reg sda_s_reg;
reg scl_d_reg;
reg sda_d_reg;

always @(posedge sys_clk) begin
    if (srst) begin
        scl_m_reg <= 1'b1;
        sda_m_reg <= 1'b1;
        scl_s_reg <= 1'b1;
        sda_s_reg <= 1'b1;
        scl_d_reg <= 1'b1;
        sda_d_reg <= 1'b1;
    end else begin
        scl_m_reg <= scl;
        sda_m_reg <= sda;
        scl_s_reg <= scl_m_reg;
        sda_s_reg <= sda_m_reg;
        scl_d_reg <= scl_s_reg;
        sda_d_reg <= sda_s_reg;
    end
end

assign sda_s = sda_s_reg;
assign scl_rise = scl_s_reg & ~scl_d_reg;
assign scl_fall = ~scl_s_reg & scl_d_reg;
// data edges while the clock stays high frame a transfer
assign start_det = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
assign stop_det = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;

endmodule // tas_pin_sync

// file: hdl/tas_top.v
// thermal alert target: registers, alert logic, two-wire sequencer
`timescale 1ns/1ps
`include "tas_defs.vh"

// Functional notes
// - polarity bit one gives active-high alert
// - polarity bit resets to zero, active low
// - mode bit one interrupt, zero comparator
// - comparator sets above trip, clears below clear
// - comparator alert ignores host reads
// - interrupt fires on either limit, read clears
// - alert needs consecutive tripping conversions
// - fault code maps to 1, 2, 4, 6
// - fault code resets to zero
// - shutdown bit enters or leaves shutdown
// - shutdown stops conversions, serial stays active
// - shutdown clears alert in interrupt mode only
// - reset gives defaults 80, 75, pointer zero
// - limits are 9-bit, half degree steps
// - each byte is eight bits plus acknowledge
// - device pulls data low in its acknowledge
// - host acknowledge asks for second byte
// - both release data in final not-acknowledge
// - device drives data bits in read transfer
// - host drives write bits, device acknowledges
// - compare nine top bits of reading
module tas_top #(
    parameter [3:0] ADDR_HI = 4'h9
) (
    input wire sys_clk,
    input wire srst,
    input wire scl,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe_n,
    input wire [2:0] addr_sel,
    input wire [10:0] temp_data,
    input wire conv_done,
    output wire conv_run,
    output wire alert_out,
    output wire alert_oe_n
);

localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_ADDR = 3'h1;
localparam [2:0] ST_ACK_A = 3'h2;
localparam [2:0] ST_WR = 3'h3;
localparam [2:0] ST_ACK_W = 3'h4;
localparam [2:0] ST_RD = 3'h5;
localparam [2:0] ST_ACK_R = 3'h6;

// signed greater-than of two limit-format values
function tas_gt;
    input [8:0] a;
    input [8:0] b;
    begin
        tas_gt = $signed(a) > $signed(b);
    end
endfunction

// consecutive faults needed for a fault-count code
function [2:0] tas_need;
    input [1:0] code;
    begin
        case (code)
            2'h0: tas_need = `TAS_FQ_N0;
            2'h1: tas_need = `TAS_FQ_N1;
            2'h2: tas_need = `TAS_FQ_N2;
            default: tas_need = `TAS_FQ_N3;
        endcase
    end
endfunction

wire sda_s;
wire scl_rise;
wire scl_fall;
wire start_det;
wire stop_det;

tas_pin_sync u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .scl(scl),
    .sda(sda_in),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
);

reg [2:0] addr_m_reg;
reg [2:0] addr_s_reg;
reg [2:0] st_reg;
reg [3:0] cnt_reg;
reg [7:0] shift_reg;
reg [7:0] out_reg;
reg rw_reg;
reg first_reg;
reg idx_reg;
reg mack_reg;
reg [1:0] ptr_reg;
reg [7:0] conf_reg;
reg [8:0] trip_reg;
reg [8:0] clr_reg;
reg [10:0] temp_reg;
reg conf_wr_reg;
reg rd_stb_reg;
reg sda_oe_n_reg;
reg sda_out_reg;
reg conv_run_reg;
reg alert_out_reg;
reg alert_oe_n_reg;
reg act_reg;
reg dir_reg;
reg [2:0] fcnt_reg;
reg [7:0] rd_byte;

wire mode_int = conf_reg[`TAS_MODE_BIT];
wire pol_high = conf_reg[`TAS_POL_BIT];
wire [1:0] fq_code = conf_reg[`TAS_FQ_HI:`TAS_FQ_LO];
wire [8:0] temp9 = temp_data[10:2];
wire hot = tas_gt(temp9, trip_reg);
wire cold = tas_gt(clr_reg, temp9);
wire hunt_cold = mode_int ? dir_reg : act_reg;
wire fault = hunt_cold ? cold : hot;
wire [2:0] fcnt_inc = fcnt_reg + 3'h1;
wire conv_ok = conv_done & conv_run_reg;
wire addr_hit = shift_reg[7:1] == {ADDR_HI, addr_s_reg};

// byte presented to the host for the current pointer and byte index
always @* begin
    case (ptr_reg)
        `TAS_PTR_TEMP:
            rd_byte = idx_reg ? {temp_reg[2:0], 5'h00} : temp_reg[10:3];
        `TAS_PTR_CONF:
            rd_byte = conf_reg;
        `TAS_PTR_CLR:
            rd_byte = idx_reg ? {clr_reg[0], 7'h00} : clr_reg[8:1];
        default:
            rd_byte = idx_reg ? {trip_reg[0], 7'h00} : trip_reg[8:1];
    endcase
end

// serial sequencer and register writes
always @(posedge sys_clk) begin
    if (srst) begin
        addr_m_reg <= 3'h0;
        addr_s_reg <= 3'h0;
        st_reg <= ST_IDLE;
        cnt_reg <= `TAS_CNT_ZERO;
        shift_reg <= 8'h00;
        out_reg <= 8'h00;
        rw_reg <= 1'b0;
        first_reg <= 1'b0;
        idx_reg <= 1'b0;
        mack_reg <= 1'b0;
        ptr_reg <= `TAS_PTR_RST;
        conf_reg <= `TAS_CONF_RST;
        trip_reg <= `TAS_TRIP_RST;
        clr_reg <= `TAS_CLR_RST;
        conf_wr_reg <= 1'b0;
        rd_stb_reg <= 1'b0;
        sda_oe_n_reg <= 1'b1;
    end else begin
        addr_m_reg <= addr_sel;
        addr_s_reg <= addr_m_reg;
        conf_wr_reg <= 1'b0;
        rd_stb_reg <= 1'b0;
        if (stop_det) begin
            st_reg <= ST_IDLE;
            sda_oe_n_reg <= 1'b1;
        end else if (start_det) begin
            // a repeated start keeps the pointer for the read
            st_reg <= ST_ADDR;
            cnt_reg <= `TAS_CNT_ZERO;
            sda_oe_n_reg <= 1'b1;
        end else begin
            case (st_reg)
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_s};
                        cnt_reg <= cnt_reg + `TAS_CNT_ONE;
                    end
                    if (scl_fall && cnt_reg == `TAS_BITS_DONE) begin
                        if (addr_hit) begin
                            sda_oe_n_reg <= 1'b0;
                            rw_reg <= shift_reg[0];
                            first_reg <= 1'b1;
                            idx_reg <= 1'b0;
                            st_reg <= ST_ACK_A;
                        end else begin
                            st_reg <= ST_IDLE;
                        end
                    end
                end
                ST_ACK_A: begin
                    if (scl_fall) begin
                        if (rw_reg) begin
                            out_reg <= rd_byte;
                            sda_oe_n_reg <= rd_byte[7];
                            cnt_reg <= `TAS_CNT_ONE;
                            st_reg <= ST_RD;
                        end else begin
                            sda_oe_n_reg <= 1'b1;
                            cnt_reg <= `TAS_CNT_ZERO;
                            st_reg <= ST_WR;
                        end
                    end
                end
                ST_WR: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_s};
                        cnt_reg <= cnt_reg + `TAS_CNT_ONE;
                    end
                    if (scl_fall && cnt_reg == `TAS_BITS_DONE) begin
                        sda_oe_n_reg <= 1'b0;
                        cnt_reg <= `TAS_CNT_ZERO;
                        st_reg <= ST_ACK_W;
                        if (first_reg) begin
                            ptr_reg <= shift_reg[1:0];
                            first_reg <= 1'b0;
                        end else begin
                            idx_reg <= ~idx_reg;
                            case (ptr_reg)
                                `TAS_PTR_CONF: begin
                                    conf_reg <= shift_reg;
                                    conf_wr_reg <= 1'b1;
                                end
                                `TAS_PTR_CLR: begin
                                    if (idx_reg)
                                        clr_reg[0] <= shift_reg[7];
                                    else
                                        clr_reg[8:1] <= shift_reg;
                                end
                                `TAS_PTR_TRIP: begin
                                    if (idx_reg)
                                        trip_reg[0] <= shift_reg[7];
                                    else
                                        trip_reg[8:1] <= shift_reg;
                                end
                                default: begin
                                end
                            endcase
                        end
                    end
                end
                ST_ACK_W: begin
                    if (scl_fall) begin
                        sda_oe_n_reg <= 1'b1;
                        st_reg <= ST_WR;
                    end
                end
                ST_RD: begin
                    if (scl_fall) begin
                        if (cnt_reg == `TAS_BITS_DONE) begin
                            sda_oe_n_reg <= 1'b1;
                            rd_stb_reg <= 1'b1;
                            idx_reg <= ~idx_reg;
                            st_reg <= ST_ACK_R;
                        end else begin
                            sda_oe_n_reg <= out_reg[6];
                            out_reg <= {out_reg[6:0], 1'b0};
                            cnt_reg <= cnt_reg + `TAS_CNT_ONE;
                        end
                    end
                end
                ST_ACK_R: begin
                    if (scl_rise)
                        mack_reg <= ~sda_s;
                    if (scl_fall) begin
                        if (mack_reg) begin
                            out_reg <= rd_byte;
                            sda_oe_n_reg <= rd_byte[7];
                            cnt_reg <= `TAS_CNT_ONE;
                            st_reg <= ST_RD;
                        end else begin
                            st_reg <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    sda_oe_n_reg <= 1'b1;
                end
            endcase
        end
    end
end

// latest conversion result, readable through the pointer
always @(posedge sys_clk) begin
    if (srst)
        temp_reg <= 11'h000;
    else if (conv_ok)
        temp_reg <= temp_data;
end

// alert state and consecutive-fault filter
always @(posedge sys_clk) begin
    if (srst) begin
        act_reg <= 1'b0;
        dir_reg <= 1'b0;
        fcnt_reg <= 3'h0;
    end else begin
        if (conf_wr_reg)
            fcnt_reg <= 3'h0;
        if (rd_stb_reg && mode_int)
            act_reg <= 1'b0;
        if (conf_wr_reg && mode_int && conf_reg[`TAS_SD_BIT])
            act_reg <= 1'b0;
        // besides the interrupt-mode clears above, only a completed conversion moves the alert
        if (conv_ok) begin
            if (!fault) begin
                fcnt_reg <= 3'h0;
            end else if (fcnt_inc >= tas_need(fq_code)) begin
                fcnt_reg <= 3'h0;
                if (mode_int) begin
                    act_reg <= 1'b1;
                    dir_reg <= ~dir_reg;
                end else begin
                    act_reg <= ~act_reg;
                end
            end else begin
                fcnt_reg <= fcnt_inc;
            end
        end
    end
end

// pin drivers
always @(posedge sys_clk) begin
    if (srst) begin
        conv_run_reg <= 1'b1;
        alert_out_reg <= 1'b0;
        alert_oe_n_reg <= 1'b1;
        sda_out_reg <= 1'b0;
    end else begin
        conv_run_reg <= ~conf_reg[`TAS_SD_BIT];
        alert_out_reg <= 1'b0;
        // open drain: pull low whenever the pin level must be low
        alert_oe_n_reg <= act_reg ? pol_high : ~pol_high;
        sda_out_reg <= 1'b0;
    end
end

assign sda_out = sda_out_reg;
assign sda_oe_n = sda_oe_n_reg;
assign conv_run = conv_run_reg;
assign alert_out = alert_out_reg;
assign alert_oe_n = alert_oe_n_reg;

endmodule // tas_top

// file: tb/tas_monitor.sv
// port checks of the thermal alert target
`timescale 1ns/1ps
module tas_monitor (
    input wire sys_clk,
    input wire srst,
    input wire scl,
    input wire sda_out,
    input wire sda_oe_n,
    input wire conv_done,
    input wire conv_run,
    input wire alert_out,
    input wire alert_oe_n
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    AST_SDA_LOW: assert property (sda_out == 1'b0)
        else $error("sda drive value not low");
    AST_ALERT_OD: assert property (alert_out == 1'b0)
        else $error("alert drive value not low");
    AST_RST_VAL: assert property ($fell(srst) |->
        sda_oe_n && alert_oe_n && conv_run)
        else $error("outputs wrong after reset");
    // alert moves only two edges after a conversion or while the serial clock is low in a host access
    AST_ALERT_CAUSE: assert property ($changed(alert_oe_n) |->
        ($past(conv_done, 2) && $past(conv_run, 2)) || !$past(scl, 2))
        else $error("alert moved without cause");
    AST_RUN_BY_WRITE: assert property ($changed(conv_run) |->
        !$past(scl, 2))
        else $error("run state moved without write");
    AST_SDA_SCL_LOW: assert property ($changed(sda_oe_n) |->
        !scl && !$past(scl))
        else $error("data line moved while clock high");
    AST_SD_HOLD: assert property (scl [*6] ##0
        (conv_done && !conv_run) |-> ##2 $stable(alert_oe_n))
        else $error("conversion taken in shutdown");
    AST_NO_EARLY: assert property (conv_done |=>
        $stable(alert_oe_n) || !$past(scl, 2))
        else $error("alert answered too early");
    cover property ($fell(alert_oe_n));
    cover property ($rose(alert_oe_n));
    cover property ($fell(sda_oe_n));
    cover property ($fell(conv_run));
endmodule // tas_monitor

// file: tb/tas_host_model.sv
// two-wire host model: serial clock source and data driver
`timescale 1ns/1ps
module tas_host_model (
    output logic scl,
    output logic sda_h,
    input wire sda
);
    initial begin
        scl = 1'b1;
        sda_h = 1'b1;
    end
    // 200 ns serial clock: data moves 50 ns into the low phase,
    // read at the rising edge
    task automatic bitx(input logic b, output logic r);
        scl = 1'b0;
        #50 sda_h = b;
        #50 scl = 1'b1;
        r = sda;
        #100;
    endtask
    task automatic start();
        logic r;
        bitx(1'b1, r);
        sda_h = 1'b0;
        #100;
    endtask
    task automatic stop();
        logic r;
        bitx(1'b0, r);
        sda_h = 1'b1;
        #100;
    endtask
    task automatic xfer(input logic [7:0] d, input logic ab,
                        output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(ab, a);
    endtask
endmodule // tas_host_model

// file: tb/tb_top.sv
// testbench top: host model, converter stimulus and scenarios
`timescale 1ns/1ps
module tb_top;
    localparam logic [6:0] ADDR = 7'h4d;
    // 90 C, above the 80 C trip limit; must stay a positive reading
    localparam logic [10:0] HOT = 11'h2d0;
    localparam logic [10:0] COLD = 11'h100;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic scl;
    logic sda_h;
    wire sda;
    logic sda_oe_n;
    logic [10:0] temp_data = 11'h000;
    logic conv_done = 1'b0;
    logic conv_run;
    logic alert_oe_n;
    logic pol = 1'b0;
    logic [15:0] v;
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;
    // open-drain line with pull-up
    assign sda = sda_h & sda_oe_n;
    tas_top #(.ADDR_HI(4'h9)) i_dut (.sys_clk(sys_clk), .srst(srst),
        .scl(scl), .sda_in(sda), .sda_out(), .sda_oe_n(sda_oe_n),
        .addr_sel(3'h5), .temp_data(temp_data), .conv_done(conv_done),
        .conv_run(conv_run), .alert_out(), .alert_oe_n(alert_oe_n));
    tas_host_model i_host (.scl(scl), .sda_h(sda_h), .sda(sda));
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            finish_test();
        end
    end
    task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic chk_al(logic act);
        cmp("alert level", {15'h0, ~(act ^ pol)}, {15'h0, alert_oe_n});
    endtask
    task automatic hdr(logic [1:0] p);
        logic a;
        logic [7:0] q;
        i_host.start();
        i_host.xfer({ADDR, 1'b0}, 1'b1, q, a);
        cmp("address ack", 16'h0, {15'h0, a});
        i_host.xfer({6'h00, p}, 1'b1, q, a);
        cmp("pointer ack", 16'h0, {15'h0, a});
    endtask
    task automatic wr(logic [1:0] p, int n, logic [15:0] d);
        logic a;
        logic [7:0] q;
        hdr(p);
        for (int i = 0; i < n; i++) begin
            i_host.xfer(d[15 - 8 * i -: 8], 1'b1, q, a);
            cmp("data ack", 16'h0, {15'h0, a});
        end
        i_host.stop();
    endtask
    task automatic rd(logic setp, logic [1:0] p, int n,
                      output logic [15:0] d);
        logic a;
        logic [7:0] q;
        d = 16'h0000;
        if (setp) hdr(p);
        i_host.start();
        i_host.xfer({ADDR, 1'b1}, 1'b1, q, a);
        cmp("read ack", 16'h0, {15'h0, a});
        for (int i = 0; i < n; i++) begin
            i_host.xfer(8'hff, i == n - 1, q, a);
            d[15 - 8 * i -: 8] = q;
        end
        i_host.stop();
    endtask
    task automatic conv(logic [10:0] t);
        @(negedge sys_clk);
        temp_data = t;
        conv_done = 1'b1;
        @(negedge sys_clk);
        conv_done = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask
    task automatic t_reset();
        chk_al(1'b0);
        cmp("conv run", 16'h1, {15'h0, conv_run});
        conv(11'h0c9);
        rd(1'b0, 2'h0, 2, v);
        cmp("temp", 16'h1920, v);
        rd(1'b1, 2'h1, 1, v);
        cmp("settings", 16'h0000, v);
        rd(1'b1, 2'h3, 2, v);
        cmp("trip", 16'h5000, v);
        rd(1'b1, 2'h2, 2, v);
        cmp("clear", 16'h4b00, v);
        $display("test reset done");
    endtask
    task automatic t_queue();
        int need[4] = '{1, 2, 4, 6};
        for (int c = 0; c < 4; c++) begin
            wr(2'h1, 1, {3'h0, c[1:0], 11'h0});
            for (int k = 1; k < need[c]; k++) conv(HOT);
            conv(11'h280);
            for (int k = 1; k < need[c]; k++) conv(HOT);
            chk_al(1'b0);
            // rewriting the settings must restart the count
            if (need[c] > 1) begin
                wr(2'h1, 1, {3'h0, c[1:0], 11'h0});
                conv(HOT);
                chk_al(1'b0);
                for (int k = 2; k < need[c]; k++) conv(HOT);
            end
            conv(HOT);
            chk_al(1'b1);
            rd(1'b1, 2'h1, 1, v);
            cmp("settings", {3'h0, c[1:0], 11'h0}, v);
            chk_al(1'b1);
            for (int k = 1; k < need[c]; k++) conv(COLD);
            chk_al(1'b1);
            conv(COLD);
            chk_al(1'b0);
        end
        $display("test queue done");
    endtask
    task automatic t_pol();
        wr(2'h1, 1, 16'h0400);
        pol = 1'b1;
        chk_al(1'b0);
        conv(HOT);
        chk_al(1'b1);
        conv(COLD);
        wr(2'h1, 1, 16'h0000);
        pol = 1'b0;
        chk_al(1'b0);
        $display("test polarity done");
    endtask
    task automatic t_int();
        wr(2'h1, 1, 16'h0200);
        conv(HOT);
        chk_al(1'b1);
        conv(HOT);
        rd(1'b1, 2'h0, 2, v);
        chk_al(1'b0);
        conv(COLD);
        chk_al(1'b1);
        rd(1'b1, 2'h1, 1, v);
        chk_al(1'b0);
        conv(HOT);
        wr(2'h1, 1, 16'h0300);
        chk_al(1'b0);
        cmp("conv run", 16'h0, {15'h0, conv_run});
        conv(COLD);
        chk_al(1'b0);
        rd(1'b1, 2'h1, 1, v);
        cmp("settings", 16'h0300, v);
        wr(2'h1, 1, 16'h0000);
        cmp("conv run", 16'h1, {15'h0, conv_run});
        conv(HOT);
        wr(2'h1, 1, 16'h0100);
        chk_al(1'b1);
        wr(2'h1, 1, 16'h0000);
        conv(COLD);
        $display("test interrupt done");
    endtask
    task automatic t_limits();
        wr(2'h3, 2, 16'h7d00);
        wr(2'h2, 2, 16'hff80);
        rd(1'b1, 2'h3, 2, v);
        cmp("trip", 16'h7d00, v);
        rd(1'b1, 2'h2, 2, v);
        cmp("clear", 16'hff80, v);
        conv(11'h3eb);
        chk_al(1'b0);
        conv(11'h3ec);
        chk_al(1'b1);
        conv(11'h7fc);
        chk_al(1'b1);
        conv(11'h7fb);
        chk_al(1'b0);
        $display("test limits done");
    endtask
    task automatic t_nack();
        logic a;
        logic [7:0] q;
        i_host.start();
        i_host.xfer({ADDR ^ 7'h01, 1'b0}, 1'b1, q, a);
        i_host.stop();
        cmp("foreign ack", 16'h1, {15'h0, a});
        $display("test address done");
    endtask
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge sys_clk);
        srst = 1'b0;
        repeat (4) @(negedge sys_clk);
        t_reset();
        t_queue();
        t_pol();
        t_int();
        t_limits();
        t_nack();
        finish_test();
    end
endmodule // tb_top
bind tas_top tas_monitor i_mon (.sys_clk(sys_clk), .srst(srst), .scl(scl),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .conv_done(conv_done),
    .conv_run(conv_run), .alert_out(alert_out), .alert_oe_n(alert_oe_n));
